/* File: hw/wdt_pkg.sv */
// Constants for the I/O port watchdog timer.
// Assumes a 250 MHz system clock and a 16-bit host I/O address.
package wdt_pkg;
  // ==========================================================
  // Port addresses
  localparam logic [15:0] PERIOD_PORT = 16'h0443;
  localparam logic [15:0] STOP_PORT_A = 16'h0043;
  localparam logic [15:0] STOP_PORT_B = 16'h0843;
  localparam int ADDR_W = 16;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int TICK_NS = 1000000000;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [7:0] PERIOD_RESET = 8'h01;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] COUNT_ONE = 8'h01;
  localparam int RST_PULSE_CYCLES = 16;
endpackage

/* File: hw/wdt_prescaler.sv */
// One-second tick prescaler for the watchdog.
// Assumes a single system clock; tick is a one-cycle enable pulse.
`timescale 1ns/1ps
module wdt_prescaler #(
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  output logic tick
);
  logic [31:0] cnt_ff;
  logic [31:0] nxt_cnt;
  wire last = (cnt_ff == 32'(TICK_CYCLES - 1));
  // ==========================================================
  // Counter
  // Second tick derive
  assign nxt_cnt = (clear || last) ? 32'h0000_0000 : cnt_ff + 32'h0000_0001;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0000_0000;
      tick <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick <= last && !clear;
    end
  end
endmodule

/* File: hw/io_port_watchdog_timer.sv */
// I/O port watchdog timer: period port, refresh read, stop read, cold reset out.
// Assumes host I/O strobes are single-cycle and synchronous to clk.
//
// Operation
// - A write to the period port stores the 8-bit period code.
// - Period code N selects a timeout of N seconds, 1 to 255.
// - Reading the period port enables and restarts the countdown.
// - Reading either stop port alias disables the countdown; no reset follows.
// - An expired enabled countdown drives a system cold reset.
`timescale 1ns/1ps
module io_port_watchdog_timer #(
  parameter int TICK_CYCLES = wdt_pkg::TICK_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic wdt_running,
  output logic sys_reset
);
  typedef enum logic [1:0] {IDLE, RUN, FIRE} wdt_state_e;
  wdt_state_e state_ff, nxt_state;
  logic [7:0] period_ff;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic [4:0] pulse_ff;
  logic tick;
  // ==========================================================
  // Decode
  function automatic logic is_stop(input logic [15:0] a);
    return (a == wdt_pkg::STOP_PORT_A) || (a == wdt_pkg::STOP_PORT_B);
  endfunction
  wire wr_period = io_wr && (io_addr == wdt_pkg::PERIOD_PORT);
  wire rd_refresh = io_rd && (io_addr == wdt_pkg::PERIOD_PORT);
  wire rd_stop = io_rd && is_stop(io_addr);
  wire expire = (state_ff == RUN) && tick && (count_ff == wdt_pkg::COUNT_ONE);
  wire pulse_done = (pulse_ff == 5'(wdt_pkg::RST_PULSE_CYCLES - 1));
  // Refresh also resyncs the prescaler so the full period is granted
  wdt_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_presc (
    .clk(clk),
    .rst_n(rst_n),
    .clear(rd_refresh || rd_stop),
    .tick(tick)
  );
  // ==========================================================
  // State machine
  always_comb begin
    nxt_state = state_ff;
    nxt_count = count_ff;
    case (state_ff)
      IDLE: begin
        if (rd_refresh && !rd_stop) begin
          nxt_state = RUN;
          nxt_count = period_ff;
        end
      end
      RUN: begin
        if (rd_stop) begin
          nxt_state = IDLE;
        end else if (rd_refresh) begin
          nxt_count = period_ff;
        end else if (expire) begin
          nxt_state = FIRE;
          nxt_count = wdt_pkg::COUNT_ZERO;
        end else if (tick) begin
          nxt_count = count_ff - 8'h01;
        end
      end
      FIRE: begin
        if (pulse_done) nxt_state = IDLE;
      end
      default: nxt_state = IDLE;
    endcase
  end
  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_ff <= wdt_pkg::PERIOD_RESET;
    end else if (wr_period) begin
      // Code zero held at one second, codes are whole seconds
      period_ff <= (io_wdata == wdt_pkg::COUNT_ZERO) ? wdt_pkg::COUNT_ONE : io_wdata;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= IDLE;
      count_ff <= wdt_pkg::COUNT_ZERO;
      pulse_ff <= 5'h00;
    end else begin
      state_ff <= nxt_state;
      count_ff <= nxt_count;
      pulse_ff <= (state_ff == FIRE) ? pulse_ff + 5'h01 : 5'h00;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_reset <= 1'b0;
      wdt_running <= 1'b0;
      io_rdata <= 8'h00;
    end else begin
      sys_reset <= (nxt_state == FIRE);
      wdt_running <= (nxt_state == RUN);
      io_rdata <= rd_refresh ? count_ff : 8'h00;
    end
  end
  // ==========================================================
  // Checks
  a_stop_halts: assert property (@(posedge clk) disable iff (!rst_n)
    rd_stop && state_ff != FIRE |=> !wdt_running ##1 !sys_reset)
    else $error("stop read did not halt watchdog");
  a_refresh_loads: assert property (@(posedge clk) disable iff (!rst_n)
    rd_refresh && !rd_stop && state_ff != FIRE |=> count_ff == $past(period_ff))
    else $error("refresh did not reload period");
  a_refresh_runs: assert property (@(posedge clk) disable iff (!rst_n)
    rd_refresh && !rd_stop && state_ff != FIRE |=> wdt_running)
    else $error("refresh did not enable watchdog");
  a_expire_resets: assert property (@(posedge clk) disable iff (!rst_n)
    expire && !rd_stop && !rd_refresh |=> sys_reset [*8])
    else $error("expiry did not assert reset");
  a_idle_no_reset: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == IDLE |=> !sys_reset)
    else $error("reset while watchdog idle");
  a_period_store: assert property (@(posedge clk) disable iff (!rst_n)
    wr_period && io_wdata != 8'h00 |=> period_ff == $past(io_wdata))
    else $error("period write not stored");
  a_tick_dec: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == RUN && tick && !io_rd && count_ff > 8'h01 |=> count_ff == $past(count_ff) - 8'h01)
    else $error("countdown did not decrement on tick");
  a_count_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_ff == RUN && !tick && !io_rd |=> $stable(count_ff))
    else $error("countdown moved without tick");
  c_start: cover property (@(posedge clk) disable iff (!rst_n) rd_refresh && state_ff == IDLE);
  c_refresh: cover property (@(posedge clk) disable iff (!rst_n) rd_refresh && state_ff == RUN);
  c_stop: cover property (@(posedge clk) disable iff (!rst_n) rd_stop && state_ff == RUN);
  c_fire: cover property (@(posedge clk) disable iff (!rst_n) $rose(sys_reset));
endmodule

/* File: testbench/wdt_host_model.sv */
// Host software model driving the watchdog I/O ports.
// Assumes the bench clock; accesses change at the falling edge.
`timescale 1ns/1ps
module wdt_host_model (
  input wire logic clk,
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata
);
  // ==========================================
  // Bus access
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // single access
  // The bus shows inverted values when idle, so stale data cannot pass for a hold
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_wr = wr;
    io_rd = !wr;
    @(negedge clk);
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~a;
    io_wdata = ~d;
    @(negedge clk);
  endtask
endmodule

/* File: testbench/test_io_port_watchdog_timer.sv */
// Self-checking bench for the I/O port watchdog timer.
// Assumes a short prescaler so each second lasts T clock cycles.
`timescale 1ns/1ps
module test_io_port_watchdog_timer;
  // ==========================================
  // Setup
  localparam int T = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] io_addr;
  logic io_wr, io_rd, wdt_running, sys_reset;
  logic [7:0] io_wdata, code;
  logic [15:0] lfsr = 16'hAF51;
  int failures = 0;
  int n_tests = 0;
  int cnt;
  always #2 clk = ~clk;
  wdt_host_model host_i (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata));
  io_port_watchdog_timer #(.TICK_CYCLES(T)) io_port_watchdog_timer_i (.clk(clk),
    .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(), .wdt_running(wdt_running), .sys_reset(sys_reset));
  // ==========================================
  // Helpers
  function automatic int span(input logic [7:0] c);
    return (c == 8'h00 ? 1 : int'(c)) * T;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    check(wdt_running, 1'b0);
    for (int k = 0; k < 4; k++) begin
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      code = (k == 0) ? 8'h00 : {6'h00, lfsr[1:0]} + 8'h01;
      host_i.access(1'b1, wdt_pkg::PERIOD_PORT, code);
      host_i.access(1'b0, 16'h0444, 8'h00);
      check(wdt_running, 1'b0);
      host_i.access(1'b0, wdt_pkg::PERIOD_PORT, 8'h00);
      check(wdt_running, 1'b1);
      repeat (3) begin
        repeat (span(code) - 6) @(negedge clk);
        host_i.access(1'b0, wdt_pkg::PERIOD_PORT, 8'h00);
        check(sys_reset, 1'b0);
      end
      cnt = 0;
      while (sys_reset !== 1'b1 && cnt < 2000) begin
        @(negedge clk);
        cnt++;
      end
      check(cnt >= span(code) - 4 && cnt <= span(code) + 2, 1'b1);
      repeat (15) @(negedge clk);
      check(sys_reset, 1'b1);
      repeat (2) @(negedge clk);
      check({wdt_running, sys_reset}, 2'b00);
      host_i.access(1'b0, wdt_pkg::PERIOD_PORT, 8'h00);
      host_i.access(1'b0, k[0] ? wdt_pkg::STOP_PORT_B : wdt_pkg::STOP_PORT_A, 8'h00);
      check(wdt_running, 1'b0);
      repeat (span(code) + 10) @(negedge clk);
      check(sys_reset, 1'b0);
    end
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report;
  end
endmodule
